// File: include/tca_pkg.sv
package tca_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // Line timing in ns, conversion time in ms; cycle counts derived below
  localparam int T_RESET_LOW_NS = 480000;
  localparam int T_GAP_NS = 60000;
  localparam int T_DEV_SAMPLE_NS = 30000;
  localparam int T_LOW_ONE_NS = 6000;
  localparam int T_LOW_ZERO_NS = 60000;
  localparam int T_MST_SAMPLE_NS = 13000;
  localparam int T_SLOT_NS = 70000;
  localparam int T_CONV_MAX_MS = 750;
  // Least times round up, longest times round down
  localparam int RESET_CYC = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEV_SAMPLE_CYC = (T_DEV_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_ONE_CYC = T_LOW_ONE_NS / CLK_PERIOD_NS;
  localparam int LOW_ZERO_CYC = (T_LOW_ZERO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MST_SAMPLE_CYC = T_MST_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int SLOT_CYC = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = T_CONV_MAX_MS * 1000000 / CLK_PERIOD_NS;
  // Function commands
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] CMD_READ_SP = 8'hbe;
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
  // Scratchpad byte indices
  localparam int SP_TEMP_LSB = 0;
  localparam int SP_TEMP_MSB = 1;
  localparam int SP_HIGH = 2;
  localparam int SP_LOW = 3;
  localparam int SP_CFG = 4;
  localparam int SP_READ_BYTES = 5;
  localparam int SP_WRITE_BYTES = 3;
  localparam int ID_BITS = 64;
  // Register values and fields
  localparam logic [15:0] TEMP_POR = 16'h0550;
  localparam int CFG_RES_LSB = 5;
  localparam logic [1:0] RES_12 = 2'h3;
  localparam logic [7:0] CFG_RESET = 8'h7f;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_RX, ST_TX, ST_POLL} tca_dev_state_t;
  typedef enum logic [2:0] {M_IDLE, M_RST, M_GAP, M_NEXT, M_SLOT, M_CONV} tca_mst_state_t;
  typedef enum logic [2:0] {OP_CONVERT, OP_WRITE, OP_READ, OP_READ_ID, OP_ALARM} tca_op_t;
endpackage : tca_pkg

// File: include/tca_if.sv
`timescale 1ns/10ps
interface tca_if;
  logic dq;
  logic dev_dq_o;
  logic dev_dq_oe;
  logic mst_dq_o;
  logic mst_dq_oe;
  logic strong_pullup;
  // Weak pullup gives high unless an enabled driver pulls low
  assign dq = !((dev_dq_oe && !dev_dq_o) || (mst_dq_oe && !mst_dq_o));
  modport device (input dq, output dev_dq_o, output dev_dq_oe);
  modport master (input dq, output mst_dq_o, output mst_dq_oe, output strong_pullup);
endinterface : tca_if

// File: verilog/tca_device.sv
`timescale 1ns/10ps
// Function
// - Resolutions 9 to 12 bits selectable
// - Twelve bit resolution after power-up; the device loads the stored configuration instead
// - Idle until convert command 44h
// - Store result, then return idle
// - Poll slots read 0 busy, 1 done, on external power only
// - Parasite master must not poll conversion
// - Sixteen bit sign-extended two's complement result
// - Low bits undefined at lower resolutions; forced to zero here
// - Result holds 0550h until first conversion
// - Compare result against high, low thresholds
// - Thresholds and configuration kept nonvolatile
// - Thresholds are scratchpad bytes two, three
// - Unique 64-bit identifier per device
// - Twelve bit conversion within 750 ms
// - Open-drain drive, weak pullup high
// - Alarm search answered by alarmed devices
// - Bits 11..4 compared; low inclusive
// - Alarm flag recomputed every conversion
// - Parasite master strong pullup within 10 us
module tca_device
  import tca_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_CYC,
  parameter int CONV_CYCLES = CONV_CYC,
  // Arbitrary identifier value
  parameter logic [63:0] ID_CODE = 64'h0123456789abcdef
) (
  input wire logic ref_clk,
  input wire logic resetn,
  tca_if.device link,
  input wire logic [11:0] sensor_code,
  input wire logic ext_powered,
  input wire logic [7:0] nv_high,
  input wire logic [7:0] nv_low,
  input wire logic [7:0] nv_cfg,
  output logic [15:0] temperature_result,
  output logic alarm_flag,
  output logic conv_busy,
  output logic [7:0] alarm_high_threshold,
  output logic [7:0] alarm_low_threshold,
  output logic [7:0] config_byte,
  output logic nv_update
);

  typedef struct packed {
    logic dq_s1;
    logic dq_s2;
    logic dq_prev;
    tca_dev_state_t state;
    logic [15:0] low_cnt;
    logic in_slot;
    logic [11:0] slot_cnt;
    logic [63:0] shreg;
    logic [6:0] bit_cnt;
    logic drive_low;
    logic [15:0] temp;
    logic [7:0] th;
    logic [7:0] tl;
    logic [7:0] cfg;
    logic alarm;
    logic busy;
    logic [25:0] conv_cnt;
    logic ext_pwr;
    logic loaded;
    logic nv_update;
  } tca_dev_reg_t;

  localparam tca_dev_reg_t DEV_RESET = '{
    dq_s1: 1'b1, dq_s2: 1'b1, dq_prev: 1'b1, state: ST_IDLE,
    low_cnt: 16'h0000, in_slot: 1'b0, slot_cnt: 12'h000, shreg: 64'h0,
    bit_cnt: 7'h00, drive_low: 1'b0, temp: TEMP_POR, th: REG_RESET,
    tl: REG_RESET, cfg: CFG_RESET, alarm: 1'b0, busy: 1'b0,
    conv_cnt: 26'h0, ext_pwr: 1'b1, loaded: 1'b0, nv_update: 1'b0
  };

  tca_dev_reg_t r;
  tca_dev_reg_t next_r;

  // Conversion length halves for each bit of resolution dropped
  function automatic logic [25:0] conv_len(input logic [1:0] res);
    conv_len = 26'(CONV_CYCLES) >> (RES_12 - res);
  endfunction : conv_len

  // Undefined low bits are forced to zero so reads stay repeatable
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    res_mask = 16'hffff << (RES_12 - res);
  endfunction : res_mask

  function automatic logic alarm_of(input logic [15:0] t, input logic [7:0] hi,
                                    input logic [7:0] lo);
    logic signed [7:0] t8;
    t8 = $signed(t[11:4]);
    alarm_of = (t8 <= $signed(lo)) || (t8 > $signed(hi));
  endfunction : alarm_of

  logic [1:0] res;
  logic [15:0] new_temp;
  logic fall;

  assign res = r.cfg[CFG_RES_LSB +: 2];
  // Sign copies fill bits 15 to 11
  assign new_temp = {{5{sensor_code[11]}}, sensor_code[10:0]} & res_mask(res);
  assign fall = r.dq_prev && !r.dq_s2;

  always_comb begin
    next_r = r;
    next_r.nv_update = 1'b0;
    next_r.dq_s1 = link.dq;
    next_r.dq_s2 = r.dq_s1;
    next_r.dq_prev = r.dq_s2;

    // Nonvolatile image and supply strap taken once after reset release
    if (!r.loaded) begin
      next_r.loaded = 1'b1;
      next_r.ext_pwr = ext_powered;
      next_r.th = nv_high;
      next_r.tl = nv_low;
      // The stored byte wins; reset value only covers reset and the load cycle
      next_r.cfg = nv_cfg;
    end

    if (r.busy) begin
      if (r.conv_cnt == 26'h0) begin
        next_r.busy = 1'b0;
        next_r.temp = new_temp;
        next_r.alarm = alarm_of(new_temp, r.th, r.tl);
      end else begin
        next_r.conv_cnt = r.conv_cnt - 26'h1;
      end
    end

    if (r.dq_s2) begin
      next_r.low_cnt = 16'h0000;
    end else if (r.low_cnt != 16'hffff) begin
      next_r.low_cnt = r.low_cnt + 16'h0001;
    end

    if (r.in_slot) begin
      next_r.slot_cnt = r.slot_cnt + 12'h001;
      if (r.slot_cnt == 12'(DEV_SAMPLE_CYC)) begin
        next_r.in_slot = 1'b0;
        next_r.drive_low = 1'b0;
        case (r.state)
          ST_CMD: begin
            next_r.shreg = {r.dq_s2, r.shreg[63:1]};
            next_r.bit_cnt = r.bit_cnt + 7'h01;
            if (r.bit_cnt == 7'h07) begin
              next_r.bit_cnt = 7'h00;
              if (next_r.shreg[63:56] == CMD_CONVERT) begin
                next_r.state = ST_POLL;
                if (!r.busy) begin
                  next_r.busy = 1'b1;
                  next_r.conv_cnt = conv_len(res);
                end
              end else if (next_r.shreg[63:56] == CMD_WRITE_SP) begin
                next_r.state = ST_RX;
              end else if (next_r.shreg[63:56] == CMD_READ_SP) begin
                next_r.shreg = {24'hffffff, r.cfg, r.tl, r.th, r.temp};
                next_r.bit_cnt = 7'(SP_READ_BYTES * 8);
                next_r.state = ST_TX;
              end else if (next_r.shreg[63:56] == CMD_READ_ID) begin
                next_r.shreg = ID_CODE;
                next_r.bit_cnt = 7'(ID_BITS);
                next_r.state = ST_TX;
              end else if (next_r.shreg[63:56] == CMD_ALARM_SEARCH) begin
                next_r.shreg = ID_CODE;
                next_r.bit_cnt = 7'(ID_BITS);
                next_r.state = r.alarm ? ST_TX : ST_IDLE;
              end else begin
                next_r.state = ST_IDLE;
              end
            end
          end
          ST_RX: begin
            next_r.shreg = {r.dq_s2, r.shreg[63:1]};
            next_r.bit_cnt = r.bit_cnt + 7'h01;
            if (r.bit_cnt == 7'(SP_WRITE_BYTES * 8 - 1)) begin
              next_r.th = next_r.shreg[47:40];
              next_r.tl = next_r.shreg[55:48];
              next_r.cfg = next_r.shreg[63:56];
              next_r.nv_update = 1'b1;
              next_r.state = ST_IDLE;
            end
          end
          ST_TX: begin
            next_r.shreg = r.shreg >> 1;
            next_r.bit_cnt = r.bit_cnt - 7'h01;
            if (r.bit_cnt == 7'h01) begin
              next_r.state = ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (fall && r.state != ST_IDLE) begin
      next_r.in_slot = 1'b1;
      next_r.slot_cnt = 12'h000;
      // Only pulling low is ever driven; a one is the released line
      next_r.drive_low = (r.state == ST_TX && !r.shreg[0]) ||
        (r.state == ST_POLL && r.busy && r.ext_pwr);
    end

    // A long low is a line reset; it overrides any slot in flight
    if (r.low_cnt == 16'(RESET_CYCLES)) begin
      next_r.state = ST_CMD;
      next_r.bit_cnt = 7'h00;
      next_r.in_slot = 1'b0;
      next_r.drive_low = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign link.dev_dq_o = 1'b0;
  assign link.dev_dq_oe = r.drive_low;
  assign temperature_result = r.temp;
  assign alarm_flag = r.alarm;
  assign conv_busy = r.busy;
  assign alarm_high_threshold = r.th;
  assign alarm_low_threshold = r.tl;
  assign config_byte = r.cfg;
  assign nv_update = r.nv_update;

endmodule : tca_device

// File: verilog/tca_master.sv
`timescale 1ns/10ps
module tca_master
  import tca_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_CYC,
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  tca_if.master link,
  input wire logic cmd_valid,
  input wire tca_op_t cmd_op,
  input wire logic [7:0] wr_high,
  input wire logic [7:0] wr_low,
  input wire logic [7:0] wr_cfg,
  input wire logic parasite_mode,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_temp,
  output logic [7:0] rsp_high,
  output logic [7:0] rsp_low,
  output logic [7:0] rsp_cfg,
  output logic [63:0] rsp_id,
  output logic rsp_alarm
);

  typedef struct packed {
    logic dq_s1;
    logic dq_s2;
    tca_mst_state_t state;
    tca_op_t op;
    logic ready;
    logic [25:0] cnt;
    logic [31:0] tx;
    logic [6:0] tx_left;
    logic [63:0] rx;
    logic [6:0] rx_left;
    logic poll;
    logic conv_wait;
    logic rd;
    logic low_one;
    logic samp;
    logic drive_low;
    logic strong_pu;
    logic rsp_valid;
    logic [15:0] rsp_temp;
    logic [7:0] rsp_high;
    logic [7:0] rsp_low;
    logic [7:0] rsp_cfg;
    logic [63:0] rsp_id;
    logic rsp_alarm;
  } tca_mst_reg_t;

  localparam tca_mst_reg_t MST_RESET = '{
    dq_s1: 1'b1, dq_s2: 1'b1, state: M_IDLE, op: OP_CONVERT, ready: 1'b0,
    cnt: 26'h0, tx: 32'h0, tx_left: 7'h00, rx: 64'h0, rx_left: 7'h00,
    poll: 1'b0, conv_wait: 1'b0, rd: 1'b0, low_one: 1'b0, samp: 1'b0,
    drive_low: 1'b0, strong_pu: 1'b0, rsp_valid: 1'b0, rsp_temp: 16'h0,
    rsp_high: 8'h00, rsp_low: 8'h00, rsp_cfg: 8'h00, rsp_id: 64'h0,
    rsp_alarm: 1'b0
  };

  tca_mst_reg_t r;
  tca_mst_reg_t next_r;

  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.dq_s1 = link.dq;
    next_r.dq_s2 = r.dq_s1;
    next_r.cnt = r.cnt + 26'h1;
    case (r.state)
      M_IDLE: begin
        next_r.ready = 1'b1;
        next_r.cnt = 26'h0;
        if (cmd_valid && r.ready) begin
          next_r.ready = 1'b0;
          next_r.op = cmd_op;
          next_r.tx_left = 7'h08;
          next_r.rx_left = 7'h00;
          next_r.poll = 1'b0;
          next_r.conv_wait = 1'b0;
          next_r.drive_low = 1'b1;
          next_r.state = M_RST;
          case (cmd_op)
            OP_CONVERT: begin
              next_r.tx = {24'h0, CMD_CONVERT};
              next_r.poll = !parasite_mode;
              next_r.conv_wait = parasite_mode;
            end
            OP_WRITE: begin
              next_r.tx = {wr_cfg, wr_low, wr_high, CMD_WRITE_SP};
              next_r.tx_left = 7'h20;
            end
            OP_READ: begin
              next_r.tx = {24'h0, CMD_READ_SP};
              next_r.rx_left = 7'(SP_READ_BYTES * 8);
            end
            OP_READ_ID: begin
              next_r.tx = {24'h0, CMD_READ_ID};
              next_r.rx_left = 7'(ID_BITS);
            end
            default: begin
              next_r.tx = {24'h0, CMD_ALARM_SEARCH};
              next_r.rx_left = 7'(ID_BITS);
            end
          endcase
        end
      end
      M_RST: begin
        if (r.cnt == 26'(RESET_CYCLES - 1)) begin
          next_r.drive_low = 1'b0;
          next_r.cnt = 26'h0;
          next_r.state = M_GAP;
        end
      end
      M_GAP: begin
        if (r.cnt == 26'(GAP_CYC - 1)) begin
          next_r.state = M_NEXT;
        end
      end
      M_NEXT: begin
        next_r.cnt = 26'h0;
        if (r.tx_left != 7'h00) begin
          next_r.rd = 1'b0;
          next_r.low_one = r.tx[0];
          next_r.drive_low = 1'b1;
          next_r.state = M_SLOT;
        end else if (r.rx_left != 7'h00 || r.poll) begin
          next_r.rd = 1'b1;
          next_r.low_one = 1'b1;
          next_r.drive_low = 1'b1;
          next_r.state = M_SLOT;
        end else if (r.conv_wait) begin
          // Strong pullup on the cycle after the command byte ends
          next_r.conv_wait = 1'b0;
          next_r.strong_pu = 1'b1;
          next_r.state = M_CONV;
        end else begin
          next_r.rsp_valid = 1'b1;
          next_r.state = M_IDLE;
          if (r.op == OP_READ) begin
            next_r.rsp_temp = r.rx[39:24];
            next_r.rsp_high = r.rx[47:40];
            next_r.rsp_low = r.rx[55:48];
            next_r.rsp_cfg = r.rx[63:56];
          end else if (r.op == OP_READ_ID) begin
            next_r.rsp_id = r.rx;
          end else if (r.op == OP_ALARM) begin
            next_r.rsp_id = r.rx;
            next_r.rsp_alarm = (r.rx != 64'hffffffffffffffff);
          end
        end
      end
      M_SLOT: begin
        if (r.cnt == (r.low_one ? 26'(LOW_ONE_CYC - 1) : 26'(LOW_ZERO_CYC - 1))) begin
          next_r.drive_low = 1'b0;
        end
        if (r.cnt == 26'(MST_SAMPLE_CYC)) begin
          next_r.samp = r.dq_s2;
        end
        if (r.cnt == 26'(SLOT_CYC - 1)) begin
          next_r.state = M_NEXT;
          if (!r.rd) begin
            next_r.tx = r.tx >> 1;
            next_r.tx_left = r.tx_left - 7'h01;
          end else if (r.rx_left != 7'h00) begin
            next_r.rx = {r.samp, r.rx[63:1]};
            next_r.rx_left = r.rx_left - 7'h01;
          end else if (r.samp) begin
            next_r.poll = 1'b0;
          end
        end
      end
      M_CONV: begin
        if (r.cnt == 26'(CONV_CYCLES - 1)) begin
          next_r.strong_pu = 1'b0;
          next_r.state = M_NEXT;
        end
      end
      default: begin
        next_r.state = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= MST_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign link.mst_dq_o = 1'b0;
  assign link.mst_dq_oe = r.drive_low;
  assign link.strong_pullup = r.strong_pu;
  assign cmd_ready = r.ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_temp = r.rsp_temp;
  assign rsp_high = r.rsp_high;
  assign rsp_low = r.rsp_low;
  assign rsp_cfg = r.rsp_cfg;
  assign rsp_id = r.rsp_id;
  assign rsp_alarm = r.rsp_alarm;

endmodule : tca_master

// File: verification/tca_link_sva.sv
`timescale 1ns/10ps
module tca_link_sva
  import tca_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic dev_dq_o,
  input wire logic dev_dq_oe,
  input wire logic mst_dq_o,
  input wire logic mst_dq_oe,
  input wire logic strong_pullup,
  input wire logic ext_powered,
  input wire logic conv_busy,
  input wire logic [15:0] temperature_result,
  input wire logic alarm_flag,
  input wire logic [7:0] alarm_high_threshold,
  input wire logic [7:0] alarm_low_threshold
);
  logic [31:0] busy_len;
  logic seen_done;

  // Length of the running conversion and whether any has finished since reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_len <= '0;
      seen_done <= 1'b0;
    end else begin
      busy_len <= conv_busy ? busy_len + 32'h1 : '0;
      if ($fell(conv_busy)) begin
        seen_done <= 1'b1;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_dev_open_drain: assert property (dev_dq_o == 1'b0)
    else $error("device drives the line high");
  a_mst_open_drain: assert property (mst_dq_o == 1'b0)
    else $error("master drives the line high");
  a_pullup_line_quiet: assert property (strong_pullup |-> !mst_dq_oe && !dev_dq_oe)
    else $error("line traffic while strong pullup is on");
  a_pullup_spans_conv: assert property ($fell(strong_pullup) |-> !$past(conv_busy))
    else $error("strong pullup dropped during conversion");
  a_result_por: assert property ((!seen_done && !$fell(conv_busy)) |->
    temperature_result == TEMP_POR)
    else $error("result left power-on value before any conversion");
  a_result_on_done: assert property ($changed(temperature_result) |-> $fell(conv_busy))
    else $error("result changed outside conversion end");
  a_sign_copies: assert property (temperature_result[15:11] == {5{temperature_result[11]}})
    else $error("sign copies in result disagree");
  a_alarm_compare: assert property ($fell(conv_busy) |-> alarm_flag ==
    (($signed(temperature_result[11:4]) <= $signed(alarm_low_threshold)) ||
     ($signed(temperature_result[11:4]) > $signed(alarm_high_threshold))))
    else $error("alarm flag does not match threshold comparison");
  a_alarm_steady: assert property ($changed(alarm_flag) |-> $fell(conv_busy))
    else $error("alarm flag changed outside conversion end");
  a_conv_bounded: assert property (conv_busy |-> busy_len <= CONV_CYCLES + 1)
    else $error("conversion runs too long");
  a_poll_busy_low: assert property ((ext_powered && conv_busy && $rose(mst_dq_oe)) |->
    ##[1:8] dev_dq_oe)
    else $error("busy device did not answer poll slot with zero");
  a_parasite_silent: assert property ((!ext_powered && conv_busy) |-> !dev_dq_oe)
    else $error("parasite device pulled line during conversion");
endmodule : tca_link_sva

// File: verification/thermometer_convert_alarm_tb.sv
`timescale 1ns/10ps
module thermometer_convert_alarm_tb;
  import tca_pkg::*;
  // Short line reset and conversion so that the three scenarios fit one run;
  // the line reset must still outlast the low of a zero bit, or it cuts the byte
  localparam int RST_CYC = 3200;
  localparam int CNV_CYC = 3000;
  localparam int LIMIT_CYC = 150000;
  logic ref_clk, resetn, ext_powered, cmd_valid, parasite_mode, cmd_ready, rsp_valid;
  logic alarm_flag, conv_busy, nv_update, busy_seen;
  logic [11:0] sensor_code;
  logic [7:0] nv_high, nv_low, nv_cfg, alarm_high_threshold, alarm_low_threshold, config_byte;
  logic [15:0] temperature_result;
  tca_op_t cmd_op;
  int bad_count, checks_done, cycles;

  tca_if tca_if_i ();
  tca_device #(.RESET_CYCLES(RST_CYC), .CONV_CYCLES(CNV_CYC)) tca_device_i (
    .ref_clk(ref_clk), .resetn(resetn), .link(tca_if_i.device), .sensor_code(sensor_code),
    .ext_powered(ext_powered), .nv_high(nv_high), .nv_low(nv_low), .nv_cfg(nv_cfg),
    .temperature_result(temperature_result), .alarm_flag(alarm_flag), .conv_busy(conv_busy),
    .alarm_high_threshold(alarm_high_threshold), .alarm_low_threshold(alarm_low_threshold),
    .config_byte(config_byte), .nv_update(nv_update));
  tca_master #(.RESET_CYCLES(RST_CYC), .CONV_CYCLES(CNV_CYC)) tca_master_i (
    .ref_clk(ref_clk), .resetn(resetn), .link(tca_if_i.master), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .wr_high(8'h00), .wr_low(8'h00), .wr_cfg(8'h00),
    .parasite_mode(parasite_mode), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_temp(), .rsp_high(), .rsp_low(), .rsp_cfg(), .rsp_id(), .rsp_alarm());
  tca_link_sva #(.CONV_CYCLES(CNV_CYC)) tca_link_sva_i (
    .ref_clk(ref_clk), .resetn(resetn), .dev_dq_o(tca_if_i.dev_dq_o),
    .dev_dq_oe(tca_if_i.dev_dq_oe), .mst_dq_o(tca_if_i.mst_dq_o),
    .mst_dq_oe(tca_if_i.mst_dq_oe), .strong_pullup(tca_if_i.strong_pullup),
    .ext_powered(ext_powered), .conv_busy(conv_busy), .temperature_result(temperature_result),
    .alarm_flag(alarm_flag), .alarm_high_threshold(alarm_high_threshold),
    .alarm_low_threshold(alarm_low_threshold));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (conv_busy === 1'b1) begin
      busy_seen = 1'b1;
    end
    if (cycles == LIMIT_CYC) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: run did not complete in time", $time);
      finish_test();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // Nonvolatile image and supply mode are taken by the device right after release
  task automatic do_reset(input logic ext, input logic [7:0] hi, input logic [7:0] lo,
                          input logic [7:0] cfg);
    @(posedge ref_clk);
    #1;
    resetn = 1'b0;
    ext_powered = ext;
    parasite_mode = !ext;
    nv_high = hi;
    nv_low = lo;
    nv_cfg = cfg;
    repeat (5) @(posedge ref_clk);
    #1;
    chk_word({8'h00, config_byte}, {8'h00, CFG_RESET}, "configuration in reset");
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_word(temperature_result, TEMP_POR, "power-on result");
    chk_word({8'h00, config_byte}, {8'h00, cfg}, "stored configuration");
    chk_word({alarm_high_threshold, alarm_low_threshold}, {hi, lo}, "thresholds");
    chk_bit(conv_busy, 1'b0, "idle after power-up");
  endtask : do_reset

  task automatic do_convert(input logic [11:0] sensor);
    int n;
    sensor_code = sensor;
    busy_seen = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n = n + 1;
    end
    cmd_op = OP_CONVERT;
    cmd_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 60000) begin
      @(posedge ref_clk);
      #1;
      n = n + 1;
    end
    chk_bit(rsp_valid, 1'b1, "convert finished");
    chk_bit(busy_seen, 1'b1, "conversion started by command");
    chk_bit(conv_busy, 1'b0, "idle after conversion");
  endtask : do_convert

  task automatic test_negative_alarm();
    do_reset(1'b1, 8'h19, 8'hf6, CFG_RESET);
    do_convert(12'hf5e);
    chk_word(temperature_result, 16'hff5e, "negative result");
    chk_bit(alarm_flag, 1'b1, "alarm below low threshold");
  endtask : test_negative_alarm

  // Equal to the high threshold is not an alarm, so the earlier flag must go away
  task automatic test_alarm_clears();
    do_convert(12'h191);
    chk_word(temperature_result, 16'h0191, "positive result");
    chk_bit(alarm_flag, 1'b0, "alarm cleared by new conversion");
  endtask : test_alarm_clears

  // Stored ten-bit setting: the two lowest result bits must read as zero
  task automatic test_parasite_low_edge();
    do_reset(1'b0, 8'h7c, 8'h0a, 8'h3f);
    do_convert(12'h0ab);
    chk_word(temperature_result, 16'h00a8, "ten-bit parasite result");
    chk_bit(alarm_flag, 1'b1, "alarm at low threshold");
  endtask : test_parasite_low_edge

  initial begin
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    busy_seen = 1'b0;
    resetn = 1'b0;
    ext_powered = 1'b1;
    parasite_mode = 1'b0;
    nv_high = 8'h00;
    nv_low = 8'h00;
    nv_cfg = 8'h00;
    sensor_code = 12'h000;
    cmd_valid = 1'b0;
    cmd_op = OP_CONVERT;
    test_negative_alarm();
    test_alarm_clears();
    test_parasite_low_edge();
    finish_test();
  end
endmodule : thermometer_convert_alarm_tb
